// ==== bench/aac_host_model.sv ====
`timescale 1ns/1ns
module aac_host_model (
    // Clock
    input  wire logic clk_i,
    // Serial pins
    input  wire logic dout_i,
    output      logic cs_n_o,
    output      logic sclk_o,
    output      logic din_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o  = 1'b1;
    end

    // Sclk stands still outside frames; phases of 4 clk beat the 3-flop sync
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din_o = w[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            r[i] = dout_i;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // Released line shows no stale value
        din_o = ~din_o;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// ==== bench/tb_aac_control.sv ====
`timescale 1ns/1ns
module tb_aac_control;
    import aac_pkg::*;

    logic               clk_i     = 1'b0;
    logic               rst_n_i   = 1'b0;
    logic               sys_clk_i = 1'b0;
    logic               sys_run   = 1'b0;
    logic [9:0]         sample_i  = 10'h155;
    logic               cs_n;
    logic               sclk;
    logic               din;
    logic               dout_o;
    logic               dout_oe_o;
    wire                dout_w;
    aac_adc_status_type adc_o;
    aac_dac_bus_type    dac_o;
    aac_power_type      power_o;
    logic [15:0]        rd;
    int                 err_count = 0;
    int                 n_tests   = 0;
    int                 n_strobe  = 0;
    int                 n_hold    = 0;
    time                t_last    = 0;
    time                t_gap     = 0;

    assign dout_w = dout_oe_o ? dout_o : 1'bz;

    aac_control i_aac_control (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .cs_n_i    (cs_n),
        .sclk_i    (sclk),
        .din_i     (din),
        .dout_i    (dout_w),
        .dout_o    (dout_o),
        .dout_oe_o (dout_oe_o),
        .sys_clk_i (sys_clk_i),
        .sample_i  (sample_i),
        .adc_o     (adc_o),
        .dac_o     (dac_o),
        .power_o   (power_o)
    );

    aac_host_model i_aac_host_model (
        .clk_i  (clk_i),
        .dout_i (dout_w),
        .cs_n_o (cs_n),
        .sclk_o (sclk),
        .din_o  (din)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // System clock of 240 ns, stopped unless sys_run
    always begin
        #120;
        if (sys_run) sys_clk_i = ~sys_clk_i;
    end

    // Later samples differ so the mean shows; fourth is low so truncation shows
    always @(negedge clk_i) begin
        if (adc_o.sample_strobe === 1'b1) begin
            n_strobe++;
            t_gap = $time - t_last;
            t_last = $time;
            sample_i = (n_strobe == 3) ? 10'h155 : 10'h157;
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 12000 && adc_o.busy !== 1'b0; k++) @(negedge clk_i);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #800000;
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(dac_o, {3'b111, 12'h000, 12'h000, 12'h68C});
        check({power_o, adc_o, dout_oe_o}, 40'h0);
        $display("test reset done");
        // Registers with the system clock stopped
        i_aac_host_model.xfer({4'h2, 12'hABC}, rd);
        check(dac_o.code[1], 12'hABC);
        for (int i = 0; i < 4; i++) begin
            i_aac_host_model.xfer({4'h4, 8'h00, i[1:0], i[0], 1'b0}, rd);
            check({adc_o.reference_select, adc_o.input_select}, {i[0], i[1:0]});
        end
        check({adc_o.busy, dac_o.code[1]}, {1'b0, 12'hABC});
        $display("test registers done");
        // Start a two-sample average, divide by 2
        sys_run = 1'b1;
        repeat (100) @(negedge clk_i);
        i_aac_host_model.xfer({4'h4, 12'h495}, rd);
        check({adc_o.busy, dout_oe_o, dout_o}, 3'b111);
        i_aac_host_model.xfer({4'h4, 12'h000}, rd);
        check(adc_o.busy, 1'b1);
        wait_idle();
        check({adc_o.busy, adc_o.result_pending, dout_oe_o, dout_o}, 4'b0110);
        check(n_strobe, 2);
        check(t_gap, 40'd5760);
        i_aac_host_model.xfer(16'hFFFF, rd);
        check(rd, 16'h5580);
        check({adc_o.result_pending, dout_oe_o}, 2'b00);
        $display("test conversion done");
        // Unread result blocks the next start
        i_aac_host_model.xfer({4'h4, 12'h081}, rd);
        wait_idle();
        i_aac_host_model.xfer({4'h4, 12'h481}, rd);
        check({adc_o.busy, adc_o.result_pending, dout_oe_o, dout_o}, 4'b0110);
        i_aac_host_model.xfer({4'h4, 12'h000}, rd);
        check({adc_o.result_pending, dout_oe_o}, 2'b00);
        $display("test pending done");
        // Thirty-two samples at divide by 4, system clock paused mid-run
        i_aac_host_model.xfer({4'h4, 12'h561}, rd);
        sys_run = 1'b0;
        repeat (10) @(negedge clk_i);
        n_hold = n_strobe;
        repeat (200) @(negedge clk_i);
        check({adc_o.busy, dac_o.code[1]}, {1'b1, 12'hABC});
        check(n_strobe, n_hold);
        sys_run = 1'b1;
        wait_idle();
        check(n_strobe, 35);
        check(t_gap, 40'd11520);
        i_aac_host_model.xfer(16'hFFFF, rd);
        check(rd, 16'h5580);
        check({adc_o.result_pending, dout_oe_o}, 2'b00);
        $display("test average done");
        // Shutdown and wake
        i_aac_host_model.xfer({4'h0, 12'h003}, rd);
        check({power_o, dac_o}, {AAC_PWR_SHUTDOWN, 39'h0});
        i_aac_host_model.xfer({4'h2, 12'h123}, rd);
        check({power_o, dac_o}, {AAC_PWR_NORMAL, 3'b111, 24'h000ABC, 12'h68C});
        $display("test shutdown done");
        wrap_up();
    end
endmodule

// ==== core/aac_consts.svh ====
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH

// Serial command layout
`define AAC_CMD_BITS      5'h10
`define AAC_ADDR_MSB      15
`define AAC_ADDR_LSB      12
`define AAC_DATA_MSB      11

// Command addresses
`define AAC_ADDR_POWER    4'h0
`define AAC_ADDR_DAC_FREQ 4'h1
`define AAC_ADDR_DAC_GA   4'h2
`define AAC_ADDR_DAC_GB   4'h3
`define AAC_ADDR_ADC_CTL  4'h4

// Reset values
`define AAC_DAC_FREQ_RST  12'h68C
`define AAC_DAC_GAIN_RST  12'h000
`define AAC_ADC_CTL_RST   11'h000

// Conversion sequencing
`define AAC_EDGE_SAMPLE   4'h0
`define AAC_EDGE_LOAD     4'hB
`define AAC_AVG_MAX_SHIFT 3'h5
`define AAC_DOUT_BITS     4'hA

// Host timing
`define AAC_SETTLE_NS     3800
`define AAC_CONV_CLK_MAX_HZ 4000000

`endif

// ==== core/aac_control.sv ====
`timescale 1ns/1ns
`include "aac_consts.svh"

// How it works
// - Stopped system clock freezes the conversion.
// - DAC updates work without system clock.
// - Power-up: frequency DAC 1.1V, gains zero.
// - Shutdown zeroes DACs; wake restores them.
// - Start bit begins conversion, self-clears.
// - Start writes ignored during a conversion.
// - Reference select: zero bandgap, one supply.
// - Input select routes four-way multiplexer.
// - Averaging field sets conversions per start.
// - Each conversion takes twelve conversion edges.
// - Conversion clock is system clock over 2^n.
// - Output enable gates result onto serial output.
// - Sixteen-bit MSB-first commands, latched on deselect.
// - Serial output high busy, low when ready.
// - Unread result blocks further conversions.
module aac_control (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // Serial port pins
    input  wire logic                    cs_n_i,
    input  wire logic                    sclk_i,
    input  wire logic                    din_i,
    input  wire logic                    dout_i,
    output      logic                    dout_o,
    output      logic                    dout_oe_o,
    // System clock pin
    input  wire logic                    sys_clk_i,
    // Converter analog side
    input  wire logic [9:0]              sample_i,
    output      aac_pkg::aac_adc_status_type adc_o,
    output      aac_pkg::aac_dac_bus_type    dac_o,
    output      aac_pkg::aac_power_type      power_o
);
    import aac_pkg::*;

    typedef struct packed {
        logic             cs_s1, cs_s2, cs_d;
        logic             sck_s1, sck_s2, sck_d;
        logic             din_s1, din_s2;
        logic             sys_s1, sys_s2, sys_d;
        logic [15:0]      shift;
        logic [4:0]       bitcnt;
        aac_adc_ctl_type  ctl;
        logic [2:0][11:0] dac;
        aac_dac_bus_type  dac_out;
        aac_power_type    pmode;
        aac_conv_type     phase;
        logic             pending;
        logic             reading;
        logic             strobe;
        logic [3:0]       edge_cnt;
        logic [4:0]       avg_cnt;
        logic [6:0]       div_cnt;
        logic [14:0]      acc;
        logic [9:0]       sample;
        logic [9:0]       result;
        logic [9:0]       out_sh;
        logic             dout;
        logic             dout_oe;
    } aac_state_type;

    aac_state_type st;
    aac_state_type next_st;

    // Averaging code to power-of-two exponent, 11x and 101 both 32
    function automatic logic [2:0] avg_shift(input logic [2:0] code);
        avg_shift = (code > `AAC_AVG_MAX_SHIFT) ? `AAC_AVG_MAX_SHIFT : code;
    endfunction

    function automatic logic [6:0] div_last(input logic [2:0] code);
        div_last = 7'(({1'b0, 7'h7F} >> (3'h7 - code)));
    endfunction

    logic       cs_rise;
    logic       cs_fall;
    logic       sck_rise;
    logic       sck_fall;
    logic       sys_rise;
    logic       conv_tick;
    logic       latch;
    logic [3:0] cmd_addr;
    logic [11:0] cmd_data;
    logic [14:0] acc_sum;
    logic [4:0]  avg_last;

    always_comb begin
        next_st = st;
        next_st.cs_s1  = cs_n_i;
        next_st.cs_s2  = st.cs_s1;
        next_st.cs_d   = st.cs_s2;
        next_st.sck_s1 = sclk_i;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_d  = st.sck_s2;
        next_st.din_s1 = din_i;
        next_st.din_s2 = st.din_s1;
        next_st.sys_s1 = sys_clk_i;
        next_st.sys_s2 = st.sys_s1;
        next_st.sys_d  = st.sys_s2;
        next_st.strobe = 1'b0;

        cs_rise  = st.cs_s2 & ~st.cs_d;
        cs_fall  = ~st.cs_s2 & st.cs_d;
        sck_rise = st.sck_s2 & ~st.sck_d;
        sck_fall = ~st.sck_s2 & st.sck_d;
        sys_rise = st.sys_s2 & ~st.sys_d;
        cmd_addr = st.shift[`AAC_ADDR_MSB:`AAC_ADDR_LSB];
        cmd_data = st.shift[`AAC_DATA_MSB:0];
        latch    = cs_rise && (st.bitcnt == `AAC_CMD_BITS);
        conv_tick = 1'b0;
        acc_sum  = st.acc + {5'h00, st.sample};
        avg_last = 5'(({4'h0, 1'b1} << avg_shift(st.ctl.average_count)) - 1);

        // Shift in on rising serial clock while selected
        if (cs_fall) begin
            next_st.bitcnt = 5'h00;
        end else if (!st.cs_s2 && sck_rise && st.pmode != AAC_PWR_SHUTDOWN) begin
            next_st.shift = {st.shift[14:0], st.din_s2};
            if (st.bitcnt != `AAC_CMD_BITS) begin
                next_st.bitcnt = st.bitcnt + 5'h01;
            end
        end

        // Conversion sequencing; only system clock edges advance it
        if (st.phase == AAC_CV_RUN && sys_rise) begin
            if (st.div_cnt == div_last(st.ctl.clock_divider)) begin
                next_st.div_cnt = 7'h00;
                conv_tick = 1'b1;
            end else begin
                next_st.div_cnt = st.div_cnt + 7'h01;
            end
        end
        if (conv_tick) begin
            if (st.edge_cnt == `AAC_EDGE_SAMPLE) begin
                next_st.sample = sample_i;
                next_st.strobe = 1'b1;
            end
            if (st.edge_cnt == `AAC_EDGE_LOAD) begin
                next_st.edge_cnt = 4'h0;
                next_st.acc = acc_sum;
                if (st.avg_cnt == avg_last) begin
                    next_st.result = 10'(acc_sum >> avg_shift(st.ctl.average_count));
                    next_st.phase = AAC_CV_IDLE;
                    next_st.pending = 1'b1;
                    next_st.ctl.start_convert = 1'b0;
                end else begin
                    next_st.avg_cnt = st.avg_cnt + 5'h01;
                end
            end else begin
                next_st.edge_cnt = st.edge_cnt + 4'h1;
            end
        end

        // Result readout: falling serial clock, last bit repeats
        if (cs_fall && st.pending && st.ctl.result_output_enable
                && st.phase == AAC_CV_IDLE && st.pmode != AAC_PWR_SHUTDOWN) begin
            next_st.reading = 1'b1;
            next_st.out_sh = st.result;
        end else if (st.reading && !st.cs_s2 && sck_fall) begin
            next_st.out_sh = {st.out_sh[8:0], st.out_sh[0]};
        end
        if (cs_rise && st.reading) begin
            next_st.reading = 1'b0;
            next_st.pending = 1'b0;
        end

        // Command latch; in shutdown only the wake edge counts
        if (cs_rise && st.pmode == AAC_PWR_SHUTDOWN) begin
            next_st.pmode = AAC_PWR_NORMAL;
        end else if (latch) begin
            unique case (cmd_addr)
                `AAC_ADDR_POWER: begin
                    next_st.pmode = aac_power_type'(cmd_data[1:0]);
                end
                `AAC_ADDR_DAC_FREQ: begin
                    next_st.dac[0] = cmd_data;
                end
                `AAC_ADDR_DAC_GA: begin
                    next_st.dac[1] = cmd_data;
                end
                `AAC_ADDR_DAC_GB: begin
                    next_st.dac[2] = cmd_data;
                end
                `AAC_ADDR_ADC_CTL: begin
                    // Whole word dropped while running so the divider stays put
                    if (st.phase == AAC_CV_IDLE) begin
                        if (!cmd_data[0]) begin
                            next_st.ctl = aac_adc_ctl_type'(cmd_data[10:0]);
                            next_st.pending = 1'b0;
                        end else if (!next_st.pending) begin
                            next_st.ctl = aac_adc_ctl_type'(cmd_data[10:0]);
                            next_st.phase = AAC_CV_RUN;
                            next_st.edge_cnt = 4'h0;
                            next_st.avg_cnt = 5'h00;
                            next_st.div_cnt = 7'h00;
                            next_st.acc = 15'h0000;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Registered outputs follow the next state
        for (int i = 0; i < 3; i++) begin
            next_st.dac_out.code[i] = (next_st.pmode == AAC_PWR_SHUTDOWN) ?
                                      12'h000 : next_st.dac[i];
            next_st.dac_out.enable[i] = (next_st.pmode != AAC_PWR_SHUTDOWN);
        end
        next_st.dout_oe = (next_st.phase == AAC_CV_RUN) || next_st.pending;
        next_st.dout = (next_st.phase == AAC_CV_RUN) ? 1'b1 :
                       next_st.reading ? next_st.out_sh[9] : 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.cs_s1 <= 1'b1;
            st.cs_s2 <= 1'b1;
            st.cs_d <= 1'b1;
            st.ctl <= aac_adc_ctl_type'(`AAC_ADC_CTL_RST);
            st.dac[0] <= `AAC_DAC_FREQ_RST;
            st.dac[1] <= `AAC_DAC_GAIN_RST;
            st.dac[2] <= `AAC_DAC_GAIN_RST;
            st.dac_out.code[0] <= `AAC_DAC_FREQ_RST;
            st.dac_out.code[1] <= `AAC_DAC_GAIN_RST;
            st.dac_out.code[2] <= `AAC_DAC_GAIN_RST;
            st.dac_out.enable <= 3'h7;
            st.pmode <= AAC_PWR_NORMAL;
            st.phase <= AAC_CV_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign dout_o    = st.dout;
    assign dout_oe_o = st.dout_oe;
    assign dac_o     = st.dac_out;
    assign power_o   = st.pmode;
    assign adc_o.reference_select = st.ctl.reference_select;
    assign adc_o.input_select     = st.ctl.input_select;
    assign adc_o.sample_strobe    = st.strobe;
    assign adc_o.busy             = (st.phase == AAC_CV_RUN);
    assign adc_o.result_pending   = st.pending;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Conversion start, run and end
    chk_start_selfclr: assert property (
        $fell(adc_o.busy) |-> !st.ctl.start_convert && st.pending)
        else $error("start bit not cleared at conversion end");
    chk_busy_frozen: assert property (
        adc_o.busy ##1 adc_o.busy |-> $stable(st.ctl))
        else $error("control changed during conversion");
    chk_strobe_run: assert property (
        adc_o.sample_strobe |-> adc_o.busy)
        else $error("sample taken outside a conversion");
    chk_edge_range: assert property (
        st.edge_cnt <= `AAC_EDGE_LOAD)
        else $error("conversion edge count beyond twelve");

    // State held without a system clock edge or a deselect
    chk_sys_hold: assert property (
        !sys_rise |=> $stable(st.div_cnt) && $stable(st.edge_cnt))
        else $error("conversion advanced without system clock edge");
    chk_power_hold: assert property (
        !cs_rise |=> $stable(power_o))
        else $error("power mode changed without a command");

    // Serial output pin
    chk_dout_busy: assert property (
        adc_o.busy |-> dout_oe_o && dout_o)
        else $error("serial output not high while busy");
    chk_dout_ready: assert property (
        st.pending && !st.reading |-> dout_oe_o && !dout_o)
        else $error("serial output not low with result waiting");
    chk_dout_idle: assert property (
        !st.pending && !adc_o.busy |-> !dout_oe_o)
        else $error("serial output driven with nothing to show");
    chk_no_restart: assert property (
        st.pending && !st.reading && !adc_o.busy |=> !adc_o.busy)
        else $error("conversion started over unread result");
    chk_read_gated: assert property (
        st.reading |-> st.ctl.result_output_enable)
        else $error("result shifted out with output disabled");

    // DAC writes and power modes
    chk_dac_update: assert property (
        latch && cmd_addr == `AAC_ADDR_DAC_GA && st.pmode != AAC_PWR_SHUTDOWN
        |=> dac_o.code[1] == $past(cmd_data))
        else $error("DAC write did not take effect");
    chk_shutdown_state_zero: assert property (
        $rose(power_o == AAC_PWR_SHUTDOWN) |-> dac_o.code == '0 && dac_o.enable == 3'h0)
        else $error("DACs not zeroed in shutdown");
    chk_wake_restore: assert property (
        $fell(power_o == AAC_PWR_SHUTDOWN) |-> dac_o.code == st.dac)
        else $error("DACs not restored on wake");

    cov_single_conv: cover property ($fell(adc_o.busy) && st.ctl.average_count == 3'h0);
    cov_avg_conv: cover property ($fell(adc_o.busy) && st.ctl.average_count != 3'h0);
    cov_avg_max: cover property ($fell(adc_o.busy) && st.ctl.average_count == 3'h6);
    cov_readout: cover property ($fell(st.reading));
    cov_shutdown_wake: cover property ($fell(power_o == AAC_PWR_SHUTDOWN));

endmodule

// ==== core/aac_pkg.sv ====
package aac_pkg;

    typedef enum logic [1:0] {
        AAC_PWR_NORMAL,
        AAC_PWR_IDLE,
        AAC_PWR_STANDBY,
        AAC_PWR_SHUTDOWN
    } aac_power_type;

    typedef enum logic {
        AAC_CV_IDLE,
        AAC_CV_RUN
    } aac_conv_type;

    typedef struct packed {
        logic       result_output_enable;
        logic [2:0] clock_divider;
        logic [2:0] average_count;
        logic [1:0] input_select;
        logic       reference_select;
        logic       start_convert;
    } aac_adc_ctl_type;

    typedef struct packed {
        logic [2:0]       enable;
        logic [2:0][11:0] code;
    } aac_dac_bus_type;

    typedef struct packed {
        logic       reference_select;
        logic [1:0] input_select;
        logic       sample_strobe;
        logic       busy;
        logic       result_pending;
    } aac_adc_status_type;

endpackage
